// File: verilog/rfmi_top.sv
/*
  rfmi_top: regulator fault monitor and interrupt logic of a two-buck,
  two-linear power manager, with its register file.
  assumes comparator levels arrive asynchronously and a host register port
  on MCLK (read data one cycle after the read strobe).
*/
// How it works
// [R1] each buck has its own 3-bit limit
// [R2] buck limit held 20us sets flag, irq
// [R3] live buck limit bit; flag cleared writing one
// [R4] linear limit 20us: flag, live, mask
// [R5] selected warning level sets flag, live bit
// [R6] protection off: discharge only if enabled
// [R7] output low 1ms after enable: disable
// [R8] overload 1ms in operation disables regulator
// [R9] buck short: flags, running cleared, irq
// [R10] linear short: flags, running cleared, irq
// [R11] clearing short flag retries enabled regulator
// [R12] overvoltage checked in standby, active only
// [R13] overvoltage: all off, flag, status cleared
// [R14] overvoltage drives both general outputs low
// [R15] overvoltage clear ignored while present; live bit
// [R16] no enable during overvoltage or pending flag
// [R17] thermal shutdown: all off, flag, standby
// [R18] thermal flag clear ignored while hot; live
// [R19] no enable while hot or flag pending
// [R20] undervoltage: shutdown; recovery returns to standby
// [R21] unmasked reset flag after shutdown; host clears
// [R22] undervoltage or software reset restores defaults
// [R23] overvoltage filter 1us on, 20us off
// [R24] irq low while unmasked flag set
// [R25] masks gate only the irq pin
`timescale 1ns/100ps
module rfmi_top #(
  parameter int OVERLOAD_CYCLES = rfmi_pkg::OVERLOAD_CYC
) (
  input wire logic MCLK,
  input wire logic NRST,
  input wire logic [7:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR_EN,
  input wire logic RD_EN,
  output logic [7:0] RDATA,
  input wire rfmi_pkg::rfmi_sense_t SENSE_RAW,
  output logic FAULT_IRQ_N,
  output logic [3:0] REG_RUN,
  output logic [3:0] REG_DISCHARGE,
  output logic [5:0] BUCK_LIMIT_SEL,
  output logic [1:0] GENERAL_OUTPUT,
  output rfmi_pkg::rfmi_mode_t OP_MODE
);
  import rfmi_pkg::*;

  if (OVERLOAD_CYCLES < 1 || OVERLOAD_CYCLES >= (1 << CNT_W)) begin : g_chk
    $error("OVERLOAD_CYCLES out of counter range");
  end

  // one debounce step: state follows raw once raw held len cycles
  function automatic rfmi_filt_t filt_step(input rfmi_filt_t cur, input logic raw,
                                           input logic [CNT_W-1:0] len);
    rfmi_filt_t res;
    res = cur;
    if (raw == cur.state) begin
      res.cnt = '0;
    end else if (len == '0 || cur.cnt + 1'b1 >= len) begin
      res.state = raw;
      res.cnt = '0;
    end else begin
      res.cnt = cur.cnt + 1'b1;
    end
    return res;
  endfunction

  // write-one-to-clear with set winning over clear
  function automatic logic w1c(input logic flag, input logic set, input logic clr);
    return set | (flag & ~clr);
  endfunction

  localparam logic [CNT_W-1:0] LIM_LEN = CNT_W'(LIMIT_CYC);
  localparam logic [CNT_W-1:0] OVL_LEN = CNT_W'(OVERLOAD_CYCLES);
  localparam logic [CNT_W-1:0] OVP_ON_LEN = CNT_W'(OVP_RISE_CYC);
  localparam logic [CNT_W-1:0] OVP_OFF_LEN = CNT_W'(OVP_FALL_CYC);

  // input sampling and filter state
  logic [$bits(rfmi_sense_t)-1:0] sync1_r, sync2_r;
  rfmi_sense_t sense;
  rfmi_filt_t filt_r [NUM_FILT];
  rfmi_filt_t filt_nxt [NUM_FILT];

  // register file and control state
  logic [4:0] buck_ctrl_r [2];
  logic [4:0] buck_ctrl_nxt [2];
  logic [3:0] ldo_ctrl_r, ldo_ctrl_nxt;
  logic [2:0] config_r, config_nxt;
  logic [7:0] int_top_r, int_top_nxt;
  logic [3:0] int_buck_r, int_buck_nxt;
  logic [3:0] int_ldo_r, int_ldo_nxt;
  logic [5:0] mask_r, mask_nxt;
  logic sw_rst_r, sw_rst_nxt;
  logic [3:0] run_r, run_nxt;
  logic [3:0] disch_r, disch_nxt;
  logic [1:0] gpo_r, gpo_nxt;
  logic irq_n_r, irq_n_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  rfmi_mode_t mode_r, mode_nxt;

  // helper terms
  logic warn_live, tsd_live, ovp_live, uvlo_s, clr_all;
  logic [1:0] buck_lim_live, ldo_lim_live;
  logic [3:0] short_evt, reg_en, dis_en, prot_off;
  logic [7:0] wr_top, wr_buck, wr_ldo;
  logic block_all;

  assign sense = rfmi_sense_t'(sync2_r);
  assign uvlo_s = sense.uvlo;
  assign buck_lim_live = {filt_r[F_BUCK_ILIM+1].state, filt_r[F_BUCK_ILIM].state}; // R3
  assign ldo_lim_live = {filt_r[F_LDO_ILIM+1].state, filt_r[F_LDO_ILIM].state}; // R4
  assign warn_live = config_r[CF_WLVL] ? filt_r[F_WARN_HI].state
                                       : filt_r[F_WARN_LO].state; // R5
  assign tsd_live = filt_r[F_TSD].state; // R18
  assign ovp_live = filt_r[F_OVP].state; // R15
  assign clr_all = (mode_r == RFMI_SHUTDOWN) | sw_rst_r; // R22
  assign reg_en = {ldo_ctrl_r[LC_EN+1], ldo_ctrl_r[LC_EN],
                   buck_ctrl_r[1][BC_EN], buck_ctrl_r[0][BC_EN]};
  assign dis_en = {ldo_ctrl_r[LC_DIS+1], ldo_ctrl_r[LC_DIS],
                   buck_ctrl_r[1][BC_DIS], buck_ctrl_r[0][BC_DIS]};
  assign wr_top = (WR_EN && ADDR == ADDR_INT_TOP) ? WDATA : 8'h00;
  assign wr_buck = (WR_EN && ADDR == ADDR_INT_BUCK) ? WDATA : 8'h00;
  assign wr_ldo = (WR_EN && ADDR == ADDR_INT_LDO) ? WDATA : 8'h00;

  // short and overload: output under threshold 1 ms while running
  assign short_evt = {filt_r[F_LDO_UNDER+1].state, filt_r[F_LDO_UNDER].state,
                      filt_r[F_BUCK_UNDER+1].state, filt_r[F_BUCK_UNDER].state}
                     & run_r; // R7 R8

  // debounce filters for every sensed level except uvlo, which is used straight from the synchronizer
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      filt_nxt[F_BUCK_ILIM+i] = filt_step(filt_r[F_BUCK_ILIM+i], sense.buck_ilim[i],
                                          LIM_LEN); // R2
      filt_nxt[F_LDO_ILIM+i] = filt_step(filt_r[F_LDO_ILIM+i], sense.ldo_ilim[i],
                                         LIM_LEN); // R4
      // rising 1 ms, falling at once
      filt_nxt[F_BUCK_UNDER+i] = filt_step(filt_r[F_BUCK_UNDER+i],
                                           sense.buck_under[i] & run_r[i],
                                           filt_r[F_BUCK_UNDER+i].state ? '0 : OVL_LEN); // R7 R8
      filt_nxt[F_LDO_UNDER+i] = filt_step(filt_r[F_LDO_UNDER+i],
                                          sense.ldo_under[i] & run_r[2+i],
                                          filt_r[F_LDO_UNDER+i].state ? '0 : OVL_LEN); // R7 R8
    end
    filt_nxt[F_WARN_LO] = filt_step(filt_r[F_WARN_LO], sense.warn_lo, LIM_LEN);
    filt_nxt[F_WARN_HI] = filt_step(filt_r[F_WARN_HI], sense.warn_hi, LIM_LEN);
    filt_nxt[F_TSD] = filt_step(filt_r[F_TSD], sense.tsd, LIM_LEN);
    filt_nxt[F_OVP] = filt_step(filt_r[F_OVP], sense.ovp & (mode_r != RFMI_SHUTDOWN),
                                ovp_live ? OVP_OFF_LEN : OVP_ON_LEN); // R12 R23
  end

  // sampling and filter registers
  always_ff @(posedge MCLK) begin
    if (!NRST) begin
      sync1_r <= '0;
      sync2_r <= '0;
      for (int i = 0; i < NUM_FILT; i++) begin
        filt_r[i] <= '0;
      end
    end else begin
      sync1_r <= SENSE_RAW;
      sync2_r <= sync1_r;
      for (int i = 0; i < NUM_FILT; i++) begin
        filt_r[i] <= filt_nxt[i];
      end
    end
  end

  // registers, flags, regulator control and read path
  always_comb begin
    buck_ctrl_nxt = buck_ctrl_r;
    ldo_ctrl_nxt = ldo_ctrl_r;
    config_nxt = config_r;
    mask_nxt = mask_r;
    sw_rst_nxt = 1'b0;
    rdata_nxt = 8'h00;
    // control writes
    if (WR_EN) begin
      case (ADDR)
        ADDR_BUCK0_CTRL: buck_ctrl_nxt[0] = WDATA[4:0]; // R1
        ADDR_BUCK1_CTRL: buck_ctrl_nxt[1] = WDATA[4:0]; // R1
        ADDR_LDO_CTRL: ldo_ctrl_nxt = WDATA[3:0];
        ADDR_CONFIG: config_nxt = WDATA[2:0];
        ADDR_MASK: mask_nxt = WDATA[5:0];
        ADDR_RESET: sw_rst_nxt = WDATA[0]; // R22
        default: ;
      endcase
    end
    // latched flags; hardware set wins over a host clear, masks not involved
    int_top_nxt[IT_WARN] = w1c(int_top_r[IT_WARN], warn_live, wr_top[IT_WARN]); // R5 R25
    int_top_nxt[IT_TSD] = w1c(int_top_r[IT_TSD], tsd_live,
                              wr_top[IT_TSD] & ~tsd_live); // R17 R18
    int_top_nxt[IT_OVP] = w1c(int_top_r[IT_OVP], ovp_live,
                              wr_top[IT_OVP] & ~ovp_live); // R13 R15
    for (int i = 0; i < 2; i++) begin
      int_top_nxt[IT_BUCK+i] = w1c(int_top_r[IT_BUCK+i], short_evt[i],
                                   wr_top[IT_BUCK+i]); // R9
      int_top_nxt[IT_LDO+i] = w1c(int_top_r[IT_LDO+i], short_evt[2+i],
                                  wr_top[IT_LDO+i]); // R10
      int_buck_nxt[2*i+IR_LIM] = w1c(int_buck_r[2*i+IR_LIM], buck_lim_live[i],
                                     wr_buck[2*i+IR_LIM]); // R2 R3
      int_buck_nxt[2*i+IR_SC] = w1c(int_buck_r[2*i+IR_SC], short_evt[i],
                                    wr_buck[2*i+IR_SC]); // R9 R11
      int_ldo_nxt[2*i+IR_LIM] = w1c(int_ldo_r[2*i+IR_LIM], ldo_lim_live[i],
                                    wr_ldo[2*i+IR_LIM]); // R4
      int_ldo_nxt[2*i+IR_SC] = w1c(int_ldo_r[2*i+IR_SC], short_evt[2+i],
                                   wr_ldo[2*i+IR_SC]); // R10 R11
    end
    int_top_nxt[IT_RST] = w1c(int_top_r[IT_RST], 1'b0, wr_top[IT_RST]); // R21
    // shutdown or software reset restores defaults, then notes the reset
    if (clr_all) begin
      buck_ctrl_nxt[0] = BUCK_CTRL_RST; // R22
      buck_ctrl_nxt[1] = BUCK_CTRL_RST;
      ldo_ctrl_nxt = LDO_CTRL_RST;
      config_nxt = CONFIG_RST;
      mask_nxt = MASK_RST;
      int_top_nxt = 8'h00;
      int_buck_nxt = 4'h0;
      int_ldo_nxt = 4'h0;
      int_top_nxt[IT_RST] = ~MASK_RST[MK_RST]; // R21
    end
    // mode: undervoltage forces shutdown, recovery goes to standby
    if (uvlo_s) begin
      mode_nxt = RFMI_SHUTDOWN; // R20
    end else if (mode_r == RFMI_SHUTDOWN) begin
      mode_nxt = RFMI_STANDBY; // R20
    end else begin
      mode_nxt = (|run_r) ? RFMI_ACTIVE : RFMI_STANDBY; // R17
    end
    // enables are refused while any global protection is live or pending
    block_all = ovp_live | int_top_nxt[IT_OVP] | tsd_live | int_top_nxt[IT_TSD]
                | uvlo_s | clr_all; // R13 R16 R17 R19 R20
    prot_off = {int_ldo_nxt[2+IR_SC], int_ldo_nxt[IR_SC],
                int_buck_nxt[2+IR_SC], int_buck_nxt[IR_SC]}
               | {4{block_all}};
    run_nxt = reg_en & ~prot_off; // R9 R10 R11 R13 R17
    disch_nxt = prot_off & dis_en; // R6
    gpo_nxt = config_r[CF_GPO+:2] & ~{2{ovp_live | int_top_r[IT_OVP]}}; // R14
    // interrupt pin: any flag not masked
    irq_n_nxt = ~(int_top_r[IT_WARN] & ~mask_r[MK_WARN]
                  | int_top_r[IT_RST] & ~mask_r[MK_RST]
                  | (|int_top_r[IT_TSD+:6])
                  | (|(int_buck_r & {2'b10, 2'b10}))
                  | (|(int_ldo_r & {2'b10, 2'b10}))
                  | (|({int_buck_r[2+IR_LIM], int_buck_r[IR_LIM]} & ~mask_r[MK_BUCK+:2]))
                  | (|({int_ldo_r[2+IR_LIM], int_ldo_r[IR_LIM]}
                       & ~mask_r[MK_LDO+:2]))); // R2 R4 R5 R24 R25
    // read data, one cycle after the strobe
    if (RD_EN) begin
      case (ADDR)
        ADDR_BUCK0_CTRL: rdata_nxt = {3'h0, buck_ctrl_r[0]};
        ADDR_BUCK1_CTRL: rdata_nxt = {3'h0, buck_ctrl_r[1]};
        ADDR_LDO_CTRL: rdata_nxt = {4'h0, ldo_ctrl_r};
        ADDR_CONFIG: rdata_nxt = {5'h00, config_r};
        ADDR_INT_TOP: rdata_nxt = int_top_r;
        ADDR_INT_BUCK: rdata_nxt = {4'h0, int_buck_r};
        ADDR_INT_LDO: rdata_nxt = {4'h0, int_ldo_r};
        ADDR_TOP_STAT: rdata_nxt = {3'h0, mode_r, ovp_live, tsd_live, warn_live}; // R15 R18
        ADDR_REG_STAT: rdata_nxt = {ldo_lim_live, buck_lim_live, run_r}; // R3 R4
        ADDR_MASK: rdata_nxt = {2'h0, mask_r};
        default: rdata_nxt = 8'h00;
      endcase
    end
  end

  // register stage
  always_ff @(posedge MCLK) begin
    if (!NRST) begin
      buck_ctrl_r[0] <= BUCK_CTRL_RST;
      buck_ctrl_r[1] <= BUCK_CTRL_RST;
      ldo_ctrl_r <= LDO_CTRL_RST;
      config_r <= CONFIG_RST;
      int_top_r <= 8'h00;
      int_buck_r <= 4'h0;
      int_ldo_r <= 4'h0;
      mask_r <= MASK_RST;
      sw_rst_r <= 1'b0;
      run_r <= 4'h0;
      disch_r <= 4'h0;
      gpo_r <= 2'h0;
      irq_n_r <= 1'b1;
      rdata_r <= 8'h00;
      mode_r <= RFMI_SHUTDOWN;
    end else begin
      buck_ctrl_r <= buck_ctrl_nxt;
      ldo_ctrl_r <= ldo_ctrl_nxt;
      config_r <= config_nxt;
      int_top_r <= int_top_nxt;
      int_buck_r <= int_buck_nxt;
      int_ldo_r <= int_ldo_nxt;
      mask_r <= mask_nxt;
      sw_rst_r <= sw_rst_nxt;
      run_r <= run_nxt;
      disch_r <= disch_nxt;
      gpo_r <= gpo_nxt;
      irq_n_r <= irq_n_nxt;
      rdata_r <= rdata_nxt;
      mode_r <= mode_nxt;
    end
  end

  assign RDATA = rdata_r;
  assign FAULT_IRQ_N = irq_n_r;
  assign REG_RUN = run_r;
  assign REG_DISCHARGE = disch_r;
  assign BUCK_LIMIT_SEL = {buck_ctrl_r[1][BC_LIM+:3], buck_ctrl_r[0][BC_LIM+:3]}; // R1
  assign GENERAL_OUTPUT = gpo_r;
  assign OP_MODE = mode_r;
endmodule // rfmi_top

// File: pkg/rfmi_pkg.sv
/*
  rfmi_pkg: constants, types and register map of the regulator fault monitor.
  assumes a 100 MHz MCLK and an 8-bit register port with one-cycle strobes.
*/
package rfmi_pkg;
  // clock and filter times
  localparam int CLK_PERIOD_NS = 10;
  localparam int LIMIT_TIME_NS = 20000;      // 20 us current limit / thermal
  localparam int OVP_RISE_NS = 1000;         // 1 us
  localparam int OVP_FALL_NS = 20000;        // 20 us
  localparam int OVERLOAD_TIME_NS = 1000000; // 1 ms
  localparam int LIMIT_CYC = (LIMIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OVP_RISE_CYC = (OVP_RISE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OVP_FALL_CYC = (OVP_FALL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OVERLOAD_CYC = (OVERLOAD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 17;
  localparam int NUM_FILT = 12;

  // filter slots
  localparam int F_BUCK_ILIM = 0;  // 0..1
  localparam int F_LDO_ILIM = 2;   // 2..3
  localparam int F_BUCK_UNDER = 4; // 4..5
  localparam int F_LDO_UNDER = 6;  // 6..7
  localparam int F_WARN_LO = 8;
  localparam int F_WARN_HI = 9;
  localparam int F_TSD = 10;
  localparam int F_OVP = 11;

  // register offsets
  localparam logic [7:0] ADDR_BUCK0_CTRL = 8'h00;
  localparam logic [7:0] ADDR_BUCK1_CTRL = 8'h01;
  localparam logic [7:0] ADDR_LDO_CTRL = 8'h02;
  localparam logic [7:0] ADDR_CONFIG = 8'h03;
  localparam logic [7:0] ADDR_INT_TOP = 8'h04;
  localparam logic [7:0] ADDR_INT_BUCK = 8'h05;
  localparam logic [7:0] ADDR_INT_LDO = 8'h06;
  localparam logic [7:0] ADDR_TOP_STAT = 8'h07;
  localparam logic [7:0] ADDR_REG_STAT = 8'h08;
  localparam logic [7:0] ADDR_MASK = 8'h09;
  localparam logic [7:0] ADDR_RESET = 8'h0a;

  // field positions
  localparam int BC_EN = 0;       // buck ctrl: enable
  localparam int BC_DIS = 1;      // buck ctrl: discharge enable
  localparam int BC_LIM = 2;      // buck ctrl: limit select [4:2]
  localparam int LC_EN = 0;       // ldo ctrl: enable [1:0]
  localparam int LC_DIS = 2;      // ldo ctrl: discharge enable [3:2]
  localparam int CF_WLVL = 0;     // config: warning level select
  localparam int CF_GPO = 1;      // config: general outputs [2:1]
  localparam int IT_WARN = 0;     // int top bits
  localparam int IT_TSD = 1;
  localparam int IT_OVP = 2;
  localparam int IT_BUCK = 3;     // [4:3]
  localparam int IT_LDO = 5;      // [6:5]
  localparam int IT_RST = 7;
  localparam int IR_LIM = 0;      // int buck/ldo: limit flag x at 2x
  localparam int IR_SC = 1;       // short flag x at 2x+1
  localparam int MK_WARN = 0;
  localparam int MK_RST = 1;
  localparam int MK_BUCK = 2;     // [3:2]
  localparam int MK_LDO = 4;      // [5:4]

  // values after reset
  localparam logic [4:0] BUCK_CTRL_RST = 5'h02;
  localparam logic [3:0] LDO_CTRL_RST = 4'hc;
  localparam logic [2:0] CONFIG_RST = 3'h0;
  localparam logic [5:0] MASK_RST = 6'h00;

  typedef enum logic [1:0] {
    RFMI_SHUTDOWN = 2'b00,
    RFMI_STANDBY = 2'b01,
    RFMI_ACTIVE = 2'b11
  } rfmi_mode_t;

  // raw comparator levels from the analog side, all active high
  typedef struct packed {
    logic [1:0] buck_ilim;
    logic [1:0] ldo_ilim;
    logic [1:0] buck_under;
    logic [1:0] ldo_under;
    logic warn_lo;
    logic warn_hi;
    logic tsd;
    logic ovp;
    logic uvlo;
  } rfmi_sense_t;

  typedef struct packed {
    logic state;
    logic [CNT_W-1:0] cnt;
  } rfmi_filt_t;
endpackage

// File: tb/rfmi_monitor.sv
/* rfmi_monitor: port assertions of rfmi_top, bound after the module.
   assumes raw sense levels are held steady by the bench within a test. */
`timescale 1ns/100ps
module rfmi_monitor #(
  parameter int OVERLOAD_CYCLES = rfmi_pkg::OVERLOAD_CYC
) (
  input wire logic MCLK,
  input wire logic NRST,
  input wire logic [7:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR_EN,
  input wire logic RD_EN,
  input wire logic [7:0] RDATA,
  input wire rfmi_pkg::rfmi_sense_t SENSE_RAW,
  input wire logic FAULT_IRQ_N,
  input wire logic [3:0] REG_RUN,
  input wire logic [3:0] REG_DISCHARGE,
  input wire logic [5:0] BUCK_LIMIT_SEL,
  input wire logic [1:0] GENERAL_OUTPUT,
  input wire rfmi_pkg::rfmi_mode_t OP_MODE
);
  import rfmi_pkg::*;
  logic [11:0] ovp_cnt_r, ovp_cnt_nxt, tsd_cnt_r, tsd_cnt_nxt;
  logic [19:0] ovl_cnt_r, ovl_cnt_nxt;
  // run lengths of raw conditions
  always_comb begin
    ovp_cnt_nxt = SENSE_RAW.ovp ? ovp_cnt_r + 12'h1 : 12'h0;
    tsd_cnt_nxt = SENSE_RAW.tsd ? tsd_cnt_r + 12'h1 : 12'h0;
    ovl_cnt_nxt = (SENSE_RAW.buck_under[0] && REG_RUN[0]) ? ovl_cnt_r + 20'h1 : 20'h0;
  end
  // counter registers
  always_ff @(posedge MCLK) begin
    if (!NRST) begin
      ovp_cnt_r <= 12'h0;
      tsd_cnt_r <= 12'h0;
      ovl_cnt_r <= 20'h0;
    end else begin
      ovp_cnt_r <= ovp_cnt_nxt;
      tsd_cnt_r <= tsd_cnt_nxt;
      ovl_cnt_r <= ovl_cnt_nxt;
    end
  end
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!NRST);
  // steps: a live buck0 write, a held supply drop
  sequence s_bk0_wr;
    WR_EN && ADDR == ADDR_BUCK0_CTRL && OP_MODE != RFMI_SHUTDOWN;
  endsequence
  sequence s_uv_held;
    SENSE_RAW.uvlo [*6];
  endsequence
  property p_limit_sel;
    s_bk0_wr |-> ##2 BUCK_LIMIT_SEL[2:0] == $past(WDATA[4:2], 2);
  endproperty
  a_limit_sel: assert property (p_limit_sel) else $error("limit select wrong");
  property p_discharge;
    (REG_DISCHARGE & REG_RUN) == 4'h0;
  endproperty
  a_discharge: assert property (p_discharge) else $error("discharge while running");
  property p_ovp_off;
    ovp_cnt_r >= 12'h06e |-> REG_RUN == 4'h0;
  endproperty
  a_ovp_off: assert property (p_ovp_off) else $error("running in overvoltage");
  property p_ovp_gpo;
    ovp_cnt_r >= 12'h06e |-> GENERAL_OUTPUT == 2'b00;
  endproperty
  a_ovp_gpo: assert property (p_ovp_gpo) else $error("outputs high in overvoltage");
  property p_tsd_off;
    tsd_cnt_r >= 12'h7da |-> REG_RUN == 4'h0 && OP_MODE != RFMI_ACTIVE;
  endproperty
  a_tsd_off: assert property (p_tsd_off) else $error("running while hot");
  property p_uvlo;
    s_uv_held |-> OP_MODE == RFMI_SHUTDOWN && REG_RUN == 4'h0;
  endproperty
  a_uvlo: assert property (p_uvlo) else $error("no shutdown on low supply");
  property p_reset_flag;
    $rose(NRST) && !SENSE_RAW.uvlo |-> ##[2:6] !FAULT_IRQ_N;
  endproperty
  a_reset_flag: assert property (p_reset_flag) else $error("no reset event irq");
  property p_software_reset_request;
    WR_EN && ADDR == ADDR_RESET && WDATA[0] && OP_MODE != RFMI_SHUTDOWN
      |-> ##[1:4] BUCK_LIMIT_SEL == 6'h00;
  endproperty
  a_software_reset_request: assert property (p_software_reset_request) else $error("no defaults after reset");
  property p_overload;
    ovl_cnt_r <= 20'(OVERLOAD_CYCLES + 8);
  endproperty
  a_overload: assert property (p_overload) else $error("overload not tripped");
endmodule // rfmi_monitor

bind rfmi_top rfmi_monitor #(.OVERLOAD_CYCLES(OVERLOAD_CYCLES)) u_rfmi_monitor (
  .MCLK(MCLK), .NRST(NRST), .ADDR(ADDR), .WDATA(WDATA), .WR_EN(WR_EN),
  .RD_EN(RD_EN), .RDATA(RDATA), .SENSE_RAW(SENSE_RAW), .FAULT_IRQ_N(FAULT_IRQ_N),
  .REG_RUN(REG_RUN), .REG_DISCHARGE(REG_DISCHARGE), .BUCK_LIMIT_SEL(BUCK_LIMIT_SEL),
  .GENERAL_OUTPUT(GENERAL_OUTPUT), .OP_MODE(OP_MODE));

// File: tb/rfmi_host.sv
/* rfmi_host: host side of the register port, one-cycle strobes.
   assumes read data stand only in the cycle after the read strobe. */
`timescale 1ns/100ps
module rfmi_host (
  input wire logic mclk,
  output logic [7:0] addr,
  output logic [7:0] wdata,
  output logic wr_en,
  output logic rd_en,
  input wire logic [7:0] rdata
);
  // idle bus from time zero
  initial begin
    addr = 8'h00;
    wdata = 8'h00;
    wr_en = 1'b0;
    rd_en = 1'b0;
  end
  // write strobe; also the write-one clears of flags
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge mclk);
    addr <= a;
    wdata <= v;
    wr_en <= 1'b1;
    @(posedge mclk);
    wr_en <= 1'b0;
  endtask
  // read strobe, data taken one cycle on
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge mclk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge mclk);
    rd_en <= 1'b0;
    #1;
    v = rdata;
  endtask
endmodule // rfmi_host

// File: tb/tb.sv
/* tb: self-checking bench of rfmi_top with a register model.
   assumes the host model above and a shortened overload count. */
`timescale 1ns/100ps
module tb;
  import rfmi_pkg::*;
  localparam int OVL = 20;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] addr, wdata, rdata, d;
  logic wr_en, rd_en, irq_n;
  logic [3:0] run, dis;
  logic [5:0] bsel;
  logic [1:0] gout, g;
  logic [2:0] l0, l1;
  rfmi_mode_t op_mode;
  rfmi_sense_t sense = '0;
  int errors = 0;
  int compares = 0;
  int dflt [0:10] = '{2, 2, 12, 0, 0, 0, 0, 0, 0, 0, 0};
  int msk [0:10] = '{31, 31, 15, 7, 0, 0, 0, 0, 0, 63, 0};
  int mdl [0:10];
  rfmi_host u_rfmi_host (.mclk(mclk), .addr(addr), .wdata(wdata), .wr_en(wr_en),
    .rd_en(rd_en), .rdata(rdata));
  rfmi_top #(.OVERLOAD_CYCLES(OVL)) u_rfmi_top (.MCLK(mclk), .NRST(nrst), .ADDR(addr),
    .WDATA(wdata), .WR_EN(wr_en), .RD_EN(rd_en), .RDATA(rdata), .SENSE_RAW(sense),
    .FAULT_IRQ_N(irq_n), .REG_RUN(run), .REG_DISCHARGE(dis), .BUCK_LIMIT_SEL(bsel),
    .GENERAL_OUTPUT(gout), .OP_MODE(op_mode));
  always #5 mclk = ~mclk;
  // compare, count, report
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %0t saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic ci(input logic v);
    chk({7'h0, irq_n}, {7'h0, v});
  endtask
  // write mirrored into the model
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    u_rfmi_host.wr(a, v);
    if (a <= ADDR_CONFIG || a == ADDR_MASK) mdl[a] = v & msk[a];
    if (a == ADDR_RESET && v[0]) mdl = dflt;
    cyc(2);
  endtask
  task automatic rdx(input logic [7:0] a, input logic [7:0] e);
    u_rfmi_host.rd(a, d);
    chk(d, e);
  endtask
  task automatic rdb(input logic [7:0] a, input int b, input logic v);
    u_rfmi_host.rd(a, d);
    chk({7'h0, d[b]}, {7'h0, v});
  endtask
  // one raw sense bit: 0 uvlo 1 ovp 2 tsd 3 warn_hi 4 warn_lo 5 ldo0 under 7 buck0 under
  task automatic sb(input int p, input logic v);
    @(posedge mclk);
    sense[p] <= v;
  endtask
  task automatic conclude();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // watchdog
  initial begin
    #500000;
    errors++;
    $display("[ERR] %0t watchdog expired", $time);
    conclude();
  end
  // main sequence
  initial begin
    void'($urandom(32'h456470d3));
    mdl = dflt;
    repeat (16) @(posedge mclk);
    nrst <= 1'b1;
    cyc(6);
    ci(1'b0);
    rdx(ADDR_INT_TOP, 8'h80);
    for (int a = 0; a < 10; a++) if (a <= 3 || a == 9) rdx(8'(a), 8'(mdl[a]));
    wr(8'h20, 8'hff);
    rdx(8'h20, 8'h00);
    wr(ADDR_INT_TOP, 8'h80);
    ci(1'b1);
    $display("test reset done");
    for (int k = 0; k < 4; k++) begin
      l0 = 3'($urandom);
      l1 = 3'($urandom);
      wr(ADDR_BUCK0_CTRL, {3'h0, l0, 2'b10});
      wr(ADDR_BUCK1_CTRL, {3'h0, l1, 2'b00});
      chk({2'h0, bsel}, {2'h0, l1, l0});
      rdx(ADDR_BUCK0_CTRL, 8'(mdl[0]));
      rdx(ADDR_BUCK1_CTRL, 8'(mdl[1]));
    end
    $display("test limits done");
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_MASK, (i == 0) ? 8'h04 : 8'h00);
      sb((i < 2) ? 11 + i : 7 + i, 1'b1);
      cyc(2100);
      ci(i == 0);
      rdx((i < 2) ? ADDR_INT_BUCK : ADDR_INT_LDO, 8'h01 << (2 * (i % 2)));
      rdx(ADDR_REG_STAT, 8'h10 << i);
      wr(ADDR_MASK, 8'h00);
      ci(1'b0);
      sb((i < 2) ? 11 + i : 7 + i, 1'b0);
      cyc(2100);
      wr((i < 2) ? ADDR_INT_BUCK : ADDR_INT_LDO, 8'h01 << (2 * (i % 2)));
      ci(1'b1);
      rdx(ADDR_REG_STAT, 8'h00);
    end
    $display("test current limit done");
    wr(ADDR_CONFIG, 8'h01);
    sb(4, 1'b1);
    cyc(2100);
    ci(1'b1);
    sb(3, 1'b1);
    cyc(2100);
    ci(1'b0);
    rdb(ADDR_TOP_STAT, 0, 1'b1);
    sb(3, 1'b0);
    sb(4, 1'b0);
    cyc(2100);
    wr(ADDR_INT_TOP, 8'h01);
    ci(1'b1);
    wr(ADDR_CONFIG, 8'h00);
    $display("test warning done");
    wr(ADDR_BUCK0_CTRL, 8'h03);
    chk({4'h0, run}, 8'h01);
    chk({6'h0, op_mode}, {6'h0, RFMI_ACTIVE});
    sb(7, 1'b1);
    cyc(OVL + 10);
    chk({4'h0, run}, 8'h00);
    chk({7'h0, dis[0]}, 8'h01);
    ci(1'b0);
    rdx(ADDR_INT_BUCK, 8'h02);
    rdx(ADDR_INT_TOP, 8'h08);
    sb(7, 1'b0);
    cyc(4);
    wr(ADDR_INT_BUCK, 8'h02);
    chk({7'h0, run[0]}, 8'h01);
    chk({7'h0, dis[0]}, 8'h00);
    wr(ADDR_INT_TOP, 8'h08);
    ci(1'b1);
    wr(ADDR_BUCK0_CTRL, 8'h00);
    // linear short: ldo0 enabled, output held low
    wr(ADDR_LDO_CTRL, 8'h01);
    sb(5, 1'b1);
    cyc(OVL + 10);
    chk({4'h0, run}, 8'h00);
    ci(1'b0);
    rdx(ADDR_INT_LDO, 8'h02);
    rdx(ADDR_INT_TOP, 8'h20);
    sb(5, 1'b0);
    wr(ADDR_INT_LDO, 8'h02);
    chk({4'h0, run}, 8'h04);
    wr(ADDR_INT_TOP, 8'h20);
    ci(1'b1);
    wr(ADDR_LDO_CTRL, 8'h00);
    $display("test short done");
    g = 2'($urandom) | 2'b01;
    wr(ADDR_BUCK1_CTRL, 8'h01);
    wr(ADDR_LDO_CTRL, 8'h03);
    wr(ADDR_CONFIG, {5'h0, g, 1'b0});
    chk({2'h0, run, gout}, {2'h0, 4'he, g});
    sb(1, 1'b1);
    cyc(50);
    sb(1, 1'b0);
    cyc(5);
    chk({4'h0, run}, 8'h0e);
    sb(1, 1'b1);
    cyc(150);
    chk({2'h0, run, gout}, 8'h00);
    ci(1'b0);
    rdb(ADDR_REG_STAT, 1, 1'b0);
    wr(ADDR_INT_TOP, 8'h04);
    rdx(ADDR_INT_TOP, 8'h04);
    rdb(ADDR_TOP_STAT, 2, 1'b1);
    sb(1, 1'b0);
    cyc(1000);
    rdb(ADDR_TOP_STAT, 2, 1'b1);
    cyc(1100);
    rdb(ADDR_TOP_STAT, 2, 1'b0);
    chk({4'h0, run}, 8'h00);
    wr(ADDR_INT_TOP, 8'h04);
    rdx(ADDR_INT_TOP, 8'h00);
    wr(ADDR_BUCK1_CTRL, 8'h00);
    wr(ADDR_LDO_CTRL, 8'h00);
    wr(ADDR_CONFIG, 8'h00);
    $display("test overvoltage done");
    wr(ADDR_BUCK0_CTRL, 8'h01);
    sb(2, 1'b1);
    cyc(2100);
    chk({2'h0, run, op_mode}, {6'h0, RFMI_STANDBY});
    ci(1'b0);
    wr(ADDR_INT_TOP, 8'h02);
    rdb(ADDR_INT_TOP, 1, 1'b1);
    rdb(ADDR_TOP_STAT, 1, 1'b1);
    sb(2, 1'b0);
    cyc(2100);
    chk({4'h0, run}, 8'h00);
    wr(ADDR_INT_TOP, 8'h02);
    chk({4'h0, run}, 8'h01);
    ci(1'b1);
    wr(ADDR_BUCK0_CTRL, 8'h00);
    $display("test thermal done");
    wr(ADDR_BUCK0_CTRL, 8'h1c);
    sb(0, 1'b1);
    cyc(10);
    chk({bsel, op_mode}, {6'h0, RFMI_SHUTDOWN});
    u_rfmi_host.wr(ADDR_BUCK0_CTRL, 8'h1c);
    mdl = dflt;
    // overvoltage during shutdown must not be seen
    sb(1, 1'b1);
    cyc(150);
    sb(1, 1'b0);
    sb(0, 1'b0);
    cyc(10);
    chk({6'h0, op_mode}, {6'h0, RFMI_STANDBY});
    rdx(ADDR_BUCK0_CTRL, 8'(mdl[0]));
    rdx(ADDR_INT_TOP, 8'h80);
    wr(ADDR_INT_TOP, 8'h80);
    wr(ADDR_BUCK0_CTRL, 8'h0c);
    wr(ADDR_RESET, 8'h01);
    rdx(ADDR_BUCK0_CTRL, 8'(mdl[0]));
    $display("test power down done");
    conclude();
  end
endmodule // tb
